// file: common/audio_clk_pkg.sv
// Package: register map, field layout and types of the audio clock path
`default_nettype none
package audio_clk_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] PLL_CTRL_ADDR   = 32'hfff0_0010;
  localparam logic [31:0] GATE_CTRL_ADDR  = 32'hfff0_0014;
  localparam logic [31:0] STATUS_ADDR     = 32'hfff0_0018;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [31:0] PLL_CTRL_RESET  = 32'h0001_0000;
  localparam logic [31:0] GATE_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PLL_CTRL_MASK   = 32'h0001_ffff;
  localparam logic [31:0] GATE_CTRL_MASK  = 32'h0000_01ff;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int PD_POS   = 16;
  localparam int FB_LSB   = 7;
  localparam int FB_W     = 9;
  localparam int OD_LSB   = 5;
  localparam int OD_W     = 2;
  localparam int IN_LSB   = 0;
  localparam int IN_W     = 5;
  localparam int EN_POS   = 8;
  localparam int DIV_LSB  = 0;
  localparam int DIV_W    = 8;
  localparam int ST_RUN   = 0;
  localparam int ST_GATE  = 1;

  // Divider field plus this offset gives the division factor
  localparam logic [FB_W:0] FACTOR_OFFSET   = 10'h002;
  // Output divider codes with a factor other than two
  localparam logic [OD_W-1:0] OD_CODE_DIV1  = 2'h0;
  localparam logic [OD_W-1:0] OD_CODE_DIV4  = 2'h3;
  localparam int CREDIT_W = 12;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              powerdown;
    logic [FB_W-1:0]   feedback_div;
    logic [OD_W-1:0]   output_div;
    logic [IN_W-1:0]   input_div;
  } pll_cfg_t;

  typedef struct packed {
    logic              source_enable;
    logic [DIV_W-1:0]  divisor;
  } gate_cfg_t;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_PLL    = 2'b01,
    SEL_GATE   = 2'b10,
    SEL_STATUS = 2'b11
  } reg_sel_t;

  typedef enum logic [0:0] {
    GATE_CLOSED = 1'b0,
    GATE_OPEN   = 1'b1
  } gate_state_t;
endpackage
`default_nettype wire

// file: hdl/audio_clock_prescaler.sv
// Prescaler and glitch-free gate between the audio PLL and the serial port
`default_nettype none
module audio_clock_prescaler (
  input  wire logic                   clock,     // System clock
  input  wire logic                   rst,       // Sync reset, active high
  input  wire logic                   pll_tick,  // One pulse per PLL cycle
  input  wire audio_clk_pkg::gate_cfg_t cfg,     // Gate settings
  output var  logic                   tick_out,  // One pulse per audio clk
  output var  logic                   gate_open  // Gate state
);
  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  logic [audio_clk_pkg::DIV_W-1:0] cnt_r;
  logic [audio_clk_pkg::DIV_W-1:0] div_r;
  audio_clk_pkg::gate_state_t      state_r;
  logic                            boundary;

  // A period ends on the tick that completes divisor+1 PLL cycles
  assign boundary = pll_tick && (cnt_r == div_r);

  // Count PLL ticks; divisor is taken only at a period boundary
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
      div_r <= '0;
    end else if (boundary) begin
      cnt_r <= '0;
      div_r <= cfg.divisor;
    end else if (pll_tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Gate opens or closes only between whole periods, so no short pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= audio_clk_pkg::GATE_CLOSED;
    end else if (boundary) begin
      case (cfg.source_enable)
        1'b1:    state_r <= audio_clk_pkg::GATE_OPEN;
        default: state_r <= audio_clk_pkg::GATE_CLOSED;
      endcase
    end
  end

  // Emit the finished period only if the gate was open across it
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= boundary && (state_r == audio_clk_pkg::GATE_OPEN);
    end
  end

  assign gate_open = (state_r == audio_clk_pkg::GATE_OPEN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_gate_closed_silent;
    @(posedge clock) disable iff (rst)
    (state_r == audio_clk_pkg::GATE_CLOSED) |=> !tick_out;
  endproperty
  a_gate_closed_silent: assert property (p_gate_closed_silent)
    else $error("audio tick while gate closed");

  property p_tick_at_period_end;
    @(posedge clock) disable iff (rst)
    tick_out |-> $past(pll_tick) && ($past(cnt_r) == $past(div_r));
  endproperty
  a_tick_at_period_end: assert property (p_tick_at_period_end)
    else $error("audio tick not at end of audio_clock_divisor period");

  property p_gate_moves_at_boundary;
    @(posedge clock) disable iff (rst)
    !boundary |=> $stable(state_r);
  endproperty
  a_gate_moves_at_boundary: assert property (p_gate_moves_at_boundary)
    else $error("gate changed inside a period");
endmodule
`default_nettype wire

// file: hdl/audio_pll_clock_control.sv
// Audio PLL clock path with its AXI4-Lite register slave
// Function
// - Power-down bit stops PLL; resets to one
// - Feedback factor is nine-bit field plus two
// - Input factor is five-bit field plus two
// - Output codes divide by one, two, two, four
// - Output equals reference times feedback over input, output, capped at one tick per system clock
// - PLL fed from shared crystal reference input
// - Enable bit passes PLL output to audio
// - Audio clock is PLL over divisor plus one
`default_nettype none
module audio_pll_clock_control #(
  parameter int CREDIT_W = audio_clk_pkg::CREDIT_W  // Rate accumulator
) (
  input  wire logic        CLOCK,           // 125 MHz system clock
  input  wire logic        RST,             // Sync reset, active high
  input  wire logic        REF_CLK_IN,      // Shared crystal reference
  input  wire logic [31:0] AWADDR,          // Write address
  input  wire logic [2:0]  AWPROT,          // Unused protection
  input  wire logic        AWVALID,         // Write address valid
  output var  logic        AWREADY,         // Write address ready
  input  wire logic [31:0] WDATA,           // Write data
  input  wire logic [3:0]  WSTRB,           // Write byte enables
  input  wire logic        WVALID,          // Write data valid
  output var  logic        WREADY,          // Write data ready
  output var  logic [1:0]  BRESP,           // Write response
  output var  logic        BVALID,          // Write response valid
  input  wire logic        BREADY,          // Write response ready
  input  wire logic [31:0] ARADDR,          // Read address
  input  wire logic [2:0]  ARPROT,          // Unused protection
  input  wire logic        ARVALID,         // Read address valid
  output var  logic        ARREADY,         // Read address ready
  output var  logic [31:0] RDATA,           // Read data
  output var  logic [1:0]  RRESP,           // Read response
  output var  logic        RVALID,          // Read data valid
  input  wire logic        RREADY,          // Read data ready
  output var  logic        AUDIO_CLK_TICK,  // One pulse per audio clock
  output var  logic        AUDIO_PLL_RUNNING // PLL out of power-down
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic audio_clk_pkg::reg_sel_t decode(
    input logic [31:0] addr
  );
    if (addr == audio_clk_pkg::PLL_CTRL_ADDR) begin
      decode = audio_clk_pkg::SEL_PLL;
    end else if (addr == audio_clk_pkg::GATE_CTRL_ADDR) begin
      decode = audio_clk_pkg::SEL_GATE;
    end else if (addr == audio_clk_pkg::STATUS_ADDR) begin
      decode = audio_clk_pkg::SEL_STATUS;
    end else begin
      decode = audio_clk_pkg::SEL_NONE;
    end
  endfunction

  // Merge enabled bytes, then drop reserved bits
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = res & mask;
  endfunction

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [31:0]          pll_ctrl_r;
  logic [31:0]          gate_ctrl_r;
  logic [31:0]          aw_addr_r;
  logic [31:0]          w_data_r;
  logic [3:0]           w_strb_r;
  logic                 aw_have_r;
  logic                 w_have_r;
  audio_clk_pkg::reg_sel_t wsel;
  audio_clk_pkg::reg_sel_t rsel;
  logic                 do_write;
  logic [31:0]          status_v;
  logic                 gate_open;

  assign wsel     = decode(aw_addr_r);
  assign rsel     = decode(ARADDR);
  assign do_write = aw_have_r && w_have_r && !BVALID;

  // Address and data are taken in either order and held until the reply
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      AWREADY   <= 1'b1;
      WREADY    <= 1'b1;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_addr_r <= AWADDR;
        aw_have_r <= 1'b1;
        AWREADY   <= 1'b0;
      end else if (BVALID && BREADY) begin
        aw_have_r <= 1'b0;
        AWREADY   <= 1'b1;
      end
      if (WVALID && WREADY) begin
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
        w_have_r <= 1'b1;
        WREADY   <= 1'b0;
      end else if (BVALID && BREADY) begin
        w_have_r <= 1'b0;
        WREADY   <= 1'b1;
      end
    end
  end

  // Write response one edge after both halves are held
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= audio_clk_pkg::RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP  <= (wsel == audio_clk_pkg::SEL_PLL ||
                 wsel == audio_clk_pkg::SEL_GATE) ?
                audio_clk_pkg::RESP_OKAY : audio_clk_pkg::RESP_SLVERR;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Control registers; reserved bits are masked so they stay zero
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pll_ctrl_r  <= audio_clk_pkg::PLL_CTRL_RESET;
      gate_ctrl_r <= audio_clk_pkg::GATE_CTRL_RESET;
    end else if (do_write) begin
      if (wsel == audio_clk_pkg::SEL_PLL) begin
        pll_ctrl_r <= merge(pll_ctrl_r, w_data_r, w_strb_r,
                            audio_clk_pkg::PLL_CTRL_MASK);
      end else if (wsel == audio_clk_pkg::SEL_GATE) begin
        gate_ctrl_r <= merge(gate_ctrl_r, w_data_r, w_strb_r,
                             audio_clk_pkg::GATE_CTRL_MASK);
      end
    end
  end

  // Live state shown to software
  always_comb begin
    status_v = '0;
    status_v[audio_clk_pkg::ST_RUN]  = AUDIO_PLL_RUNNING;
    status_v[audio_clk_pkg::ST_GATE] = gate_open;
  end

  // Read answer on the same edge that takes the address
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= audio_clk_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RRESP   <= audio_clk_pkg::RESP_OKAY;
      if (rsel == audio_clk_pkg::SEL_PLL) begin
        RDATA <= pll_ctrl_r;
      end else if (rsel == audio_clk_pkg::SEL_GATE) begin
        RDATA <= gate_ctrl_r;
      end else if (rsel == audio_clk_pkg::SEL_STATUS) begin
        RDATA <= status_v;
      end else begin
        RDATA <= '0;
        RRESP <= audio_clk_pkg::RESP_SLVERR;
      end
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Audio PLL frequency model
  // ----------------------------------------------------------------
  audio_clk_pkg::pll_cfg_t  pll_cfg;
  audio_clk_pkg::gate_cfg_t gate_cfg;
  logic                     ref_s1_r;
  logic                     ref_s2_r;
  logic                     ref_s3_r;
  logic                     ref_edge;
  logic [audio_clk_pkg::IN_W:0] in_cnt_r;
  logic [audio_clk_pkg::IN_W:0] in_last;
  logic [audio_clk_pkg::FB_W:0] nf;
  logic [2:0]               no;
  logic                     div_tick_r;
  logic [CREDIT_W-1:0]      credit_r;
  logic                     emit;
  logic                     room;
  logic                     pll_tick_r;

  assign pll_cfg  = pll_ctrl_r[audio_clk_pkg::PD_POS:audio_clk_pkg::IN_LSB];
  assign gate_cfg = gate_ctrl_r[audio_clk_pkg::EN_POS:audio_clk_pkg::DIV_LSB];

  // Crystal pin is asynchronous: two flops, a third for the edge
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= REF_CLK_IN;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end
  assign ref_edge = ref_s2_r && !ref_s3_r;

  // Factors from the fields; output code 01 and 10 both halve
  assign in_last = {1'b0, pll_cfg.input_div} + 6'h01;
  assign nf = {1'b0, pll_cfg.feedback_div} +
              audio_clk_pkg::FACTOR_OFFSET;
  always_comb begin
    case (pll_cfg.output_div)
      audio_clk_pkg::OD_CODE_DIV1: no = 3'h1;
      audio_clk_pkg::OD_CODE_DIV4: no = 3'h4;
      default:                     no = 3'h2;
    endcase
  end

  // Input divider: one tick per input-factor reference edges
  always_ff @(posedge CLOCK) begin
    if (RST || pll_cfg.powerdown) begin
      in_cnt_r   <= '0;
      div_tick_r <= 1'b0;
    end else if (ref_edge && in_cnt_r >= in_last) begin
      in_cnt_r   <= '0;
      div_tick_r <= 1'b1;
    end else begin
      in_cnt_r   <= in_cnt_r + {5'h00, ref_edge};
      div_tick_r <= 1'b0;
    end
  end

  // Rate accumulator: feedback factor in, output factor out per tick.
  // Output is capped at one tick per system clock; beyond that the
  // accumulator saturates and the excess is lost.
  assign emit = (credit_r >= CREDIT_W'(no));
  assign room = (credit_r <= ({CREDIT_W{1'b1}} - CREDIT_W'(nf)));
  always_ff @(posedge CLOCK) begin
    if (RST || pll_cfg.powerdown) begin
      credit_r   <= '0;
      pll_tick_r <= 1'b0;
    end else begin
      credit_r <= credit_r
                  + ((div_tick_r && room) ? CREDIT_W'(nf) : '0)
                  - (emit ? CREDIT_W'(no) : '0);
      pll_tick_r <= emit;
    end
  end

  // Running flag straight from the power-down register bit
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      AUDIO_PLL_RUNNING <= 1'b0;
    end else begin
      AUDIO_PLL_RUNNING <= !pll_cfg.powerdown;
    end
  end

  // Prescaler and gate toward the audio serial port
  audio_clock_prescaler u_prescaler (
    .clock     (CLOCK),
    .rst       (RST),
    .pll_tick  (pll_tick_r),
    .cfg       (gate_cfg),
    .tick_out  (AUDIO_CLK_TICK),
    .gate_open (gate_open)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pd_no_tick;
    @(posedge CLOCK) disable iff (RST)
    pll_cfg.powerdown [*2] |-> !pll_tick_r && !div_tick_r;
  endproperty
  a_pd_no_tick: assert property (p_pd_no_tick)
    else $error("PLL ticking while powered down");

  property p_input_div;
    @(posedge CLOCK) disable iff (RST)
    div_tick_r |-> $past(ref_edge) && ($past(in_cnt_r) >= $past(in_last));
  endproperty
  a_input_div: assert property (p_input_div)
    else $error("input divider tick at wrong count");

  property p_feedback_add;
    @(posedge CLOCK) disable iff (RST)
    (div_tick_r && room && !emit && !pll_cfg.powerdown) |=>
      credit_r == $past(credit_r) + CREDIT_W'($past(nf));
  endproperty
  a_feedback_add: assert property (p_feedback_add)
    else $error("feedback factor not accumulated");

  property p_output_factor;
    @(posedge CLOCK) disable iff (RST)
    (emit && !div_tick_r && !pll_cfg.powerdown) |=>
      pll_tick_r && credit_r == $past(credit_r) - CREDIT_W'($past(no));
  endproperty
  a_output_factor: assert property (p_output_factor)
    else $error("output factor not taken per tick");

  property p_reserved_zero;
    @(posedge CLOCK) disable iff (RST)
    RVALID |-> ((RDATA & ~(audio_clk_pkg::PLL_CTRL_MASK |
                audio_clk_pkg::GATE_CTRL_MASK)) == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved read bits not zero");

  property p_bresp_hold;
    @(posedge CLOCK) disable iff (RST)
    (BVALID && !BREADY) |=> BVALID && $stable(BRESP);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");
endmodule
`default_nettype wire

// file: verif/audio_serial_sink.sv
// Stand-in for the audio serial port that consumes the generated clock
`default_nettype none
module audio_serial_sink (
  input  wire logic        clock,  // System clock
  input  wire logic        rst,    // Sync reset, active high
  input  wire logic        tick,   // Audio clock pulse
  input  wire logic        clear,  // Restart the counters
  output var  logic [31:0] count,  // Pulses seen
  output var  logic [31:0] wide    // Pulses right after a pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_q;

  // Each high cycle is one audio clock; fast rates send them back to back.
  // Back-to-back is impossible once the divisor is above zero, because
  // the PLL ticks at most once per clock: it would mean a cut period.
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      count  <= '0;
      wide   <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
      if (tick)
        count <= count + 32'h0000_0001;
      if (tick && tick_q)
        wide <= wide + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the audio PLL clock path and its registers
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int  SETTLE = 1000;
  localparam int  WIN    = 4000;
  localparam int  WATCH  = 60000;
  localparam real REF_HALF = 33.333;  // About a 15 MHz crystal
  localparam logic [31:0] PLL  = audio_clk_pkg::PLL_CTRL_ADDR;
  localparam logic [31:0] GATE = audio_clk_pkg::GATE_CTRL_ADDR;
  localparam logic [31:0] HOLE = 32'hfff0_001c;
  logic        clock, rst, ref_clk, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        tick, running, sink_clear;
  logic [31:0] awaddr, wdata, araddr, rdata, sink_count, sink_wide, rd_data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  int          num_errors, tests_run, ref_edges, no;
  // Entry 3 lands near 12.288 MHz
  int fbv[5] = '{6, 14, 22, 34, 511};
  int inv[5] = '{2, 0, 3, 9, 31};
  int odv[5] = '{0, 1, 2, 3, 3};
  int dvv[5] = '{0, 3, 0, 0, 255};

  audio_pll_clock_control dut_u (
    .CLOCK(clock), .RST(rst), .REF_CLK_IN(ref_clk),
    .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .AUDIO_CLK_TICK(tick), .AUDIO_PLL_RUNNING(running)
  );
  audio_serial_sink sink_u (
    .clock(clock), .rst(rst), .tick(tick), .clear(sink_clear),
    .count(sink_count), .wide(sink_wide)
  );

  // Clocks; the crystal is unrelated in phase to the system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    ref_clk = 1'b0;
    forever #(REF_HALF) ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) ref_edges++;

  // Watchdog against a hung handshake
  initial begin
    repeat (WATCH) @(posedge clock);
    num_errors++;
    $display("Error watchdog expected finish seen hang");
    close_out();
  end

  task check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task close_out;
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task axi_wr(input logic [31:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask

  task axi_rd(input logic [31:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [31:0] pll_word(logic pd, int fb, od, in);
    audio_clk_pkg::pll_cfg_t c;
    c.powerdown    = pd;
    c.feedback_div = 9'(fb);
    c.output_div   = 2'(od);
    c.input_div    = 5'(in);
    return {15'h0000, c};
  endfunction

  function automatic logic [31:0] gate_word(logic en, int dv);
    audio_clk_pkg::gate_cfg_t g;
    g.source_enable = en;
    g.divisor       = 8'(dv);
    return {23'h00_0000, g};
  endfunction

  // Tick count over a window against reference edges times a ratio
  task measure(input real ratio, input real tol, input string what);
    int  e0;
    real diff;
    repeat (SETTLE) @(posedge clock);
    sink_clear <= 1'b1;
    @(posedge clock);
    sink_clear <= 1'b0;
    e0 = ref_edges;
    repeat (WIN) @(posedge clock);
    diff = real'(sink_count) - real'(ref_edges - e0) * ratio;
    check(what, 32'(diff <= tol && diff >= -tol), 32'h0000_0001);
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sink_clear} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    rst = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    axi_rd(PLL);
    check("pll ctrl reset", rd_data, audio_clk_pkg::PLL_CTRL_RESET);
    axi_rd(GATE);
    check("gate reset", rd_data, audio_clk_pkg::GATE_CTRL_RESET);
    check("running at reset", 32'(running), 32'h0000_0000);
    $display("Done: reset values");
    axi_wr(PLL, 32'hffff_ffff);
    check("pll write resp", 32'(wr_resp), 32'h0000_0000);
    axi_rd(PLL);
    check("pll reserved", rd_data, audio_clk_pkg::PLL_CTRL_MASK);
    axi_wr(GATE, 32'hffff_ffff);
    axi_rd(GATE);
    check("gate reserved", rd_data, audio_clk_pkg::GATE_CTRL_MASK);
    wstrb <= 4'h1;
    axi_wr(GATE, 32'h0000_0000);
    wstrb <= 4'hf;
    axi_rd(GATE);
    check("gate byte lane", rd_data, 32'h0000_0100);
    measure(0.0, 0.0, "ticks while powered down");
    $display("Done: reserved bits");
    axi_wr(audio_clk_pkg::STATUS_ADDR, 32'h0000_0000);
    check("status write resp", 32'(wr_resp), 32'h0000_0002);
    axi_wr(HOLE, 32'h0000_0000);
    check("hole write resp", 32'(wr_resp), 32'h0000_0002);
    axi_rd(HOLE);
    check("hole read resp", 32'(rd_resp), 32'h0000_0002);
    check("hole read data", rd_data, 32'h0000_0000);
    axi_rd(PLL);
    check("pll after refusals", rd_data, 32'h0001_ffff);
    $display("Done: refused accesses");
    for (int i = 0; i < 5; i++) begin
      no = (odv[i] == 0) ? 1 : ((odv[i] == 3) ? 4 : 2);
      axi_wr(PLL, pll_word(1'b0, fbv[i], odv[i], inv[i]));
      axi_wr(GATE, gate_word(1'b1, dvv[i]));
      measure(real'(fbv[i] + 2) / real'((inv[i] + 2) * no * (dvv[i] + 1)),
              real'(fbv[i] + 2) / real'(no * (dvv[i] + 1)) + 3.0,
              "audio rate");
      check("running flag", 32'(running), 32'h0000_0001);
      if (dvv[i] != 0)
        check("back-to-back ticks", sink_wide, 32'h0000_0000);
    end
    axi_rd(audio_clk_pkg::STATUS_ADDR);
    check("status running", rd_data & 32'h0000_0001, 32'h0000_0001);
    check("status gate", rd_data & 32'h0000_0002, 32'h0000_0002);
    $display("Done: divider table");
    axi_wr(GATE, gate_word(1'b0, 0));
    measure(0.0, 0.0, "ticks with gate off");
    axi_wr(GATE, gate_word(1'b1, 0));
    axi_wr(PLL, pll_word(1'b1, 6, 0, 2));
    measure(0.0, 0.0, "ticks after power down");
    check("running after power down", 32'(running), 32'h0000_0000);
    check("stretched pulses", sink_wide, 32'h0000_0000);
    $display("Done: gate and power down");
    close_out();
  end
endmodule
`default_nettype wire
